// ---- rtl/lsdc_pkg.sv ----
// Shared constants and types for the LED dimming and sleep control block.
// Assumes a single 10 MHz system clock; the RTL block and the bench refer to names here.
package lsdc_pkg;

	localparam int CLK_HZ = 10_000_000;
	localparam int CLK_PER_US = CLK_HZ / 1_000_000;
	localparam int NPIN = 10;

	// Sleep intervals in microseconds, and their cycle counts
	localparam int SLP_US_512HZ = 1950;
	localparam int SLP_US_64HZ = 15600;
	localparam int SLP_US_8HZ = 125000;
	localparam int SLP_US_1HZ = 1000000;
	localparam int SLP_CYC_512HZ = SLP_US_512HZ * CLK_PER_US;
	localparam int SLP_CYC_64HZ = SLP_US_64HZ * CLK_PER_US;
	localparam int SLP_CYC_8HZ = SLP_US_8HZ * CLK_PER_US;
	localparam int SLP_CYC_1HZ = SLP_US_1HZ * CLK_PER_US;
	localparam int SLP_CNT_W = 24;

	// Half period of the flash mode blink
	localparam int FLASH_US = 250000;
	localparam int FLASH_CYC = FLASH_US * CLK_PER_US;
	localparam int FLASH_CNT_W = 22;

	// PWM: 4-bit counter, duty compared against it
	localparam int PWM_W = 4;
	localparam logic [3:0] PWM_TOP = 4'hF;

	// I2C slave
	localparam logic [6:0] I2C_ADDR_RST = 7'h10;
	localparam int CMD_BIT = 7;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] LAST_TX_BIT = 4'h7;

	typedef enum logic [1:0] {
		DIM_FOLLOW = 2'b00,
		DIM_FLASH = 2'b01,
		DIM_HOLD = 2'b10,
		DIM_TOGGLE = 2'b11
	} lsdc_dim_t;

	typedef enum logic [1:0] {
		PWR_ACTIVE = 2'b00,
		PWR_SLEEP = 2'b01,
		PWR_DEEP = 2'b10
	} lsdc_pwr_t;

	typedef enum logic [1:0] {
		PS_RUN = 2'b00,
		PS_SLEEP = 2'b01,
		PS_SCAN = 2'b10,
		PS_DEEP = 2'b11
	} lsdc_pst_t;

	typedef enum logic [2:0] {
		I2_IDLE = 3'b000,
		I2_ADDR = 3'b001,
		I2_AACK = 3'b010,
		I2_WDAT = 3'b011,
		I2_WACK = 3'b100,
		I2_RDAT = 3'b101,
		I2_RACK = 3'b110
	} lsdc_i2st_t;

	typedef struct packed {
		logic [9:0] pinEn;
		logic [3:0] duty;
		lsdc_dim_t mode;
		logic idleLevel;
	} lsdc_pwmcfg_t;

	typedef struct packed {
		logic en;
		logic intEn;
		logic [3:0] pinSel;
	} lsdc_slpctl_t;

	typedef struct packed {
		logic regWr;
		logic cmd;
		logic [6:0] idx;
		logic [7:0] data;
	} lsdc_i2creq_t;

endpackage

// ---- rtl/lsdc_led_sleep_ctrl.sv ----
// LED dimming PWM, power mode sequencer, sleep-control pin and I2C slave.
// Assumes all inputs synchronous to clk_sys; sensing and register storage sit outside.
// Notes on behaviour
// - Slave address is loaded from a configuration write, not fixed.
// - After the lock flag is set, address writes are ignored.
// - I2C traffic either accesses registers or issues commands.
// - One PWM generator feeds every pin; one shared duty cycle.
// - Each enabled pin drives the PWM wave or a static 0/1.
// - Four dimming modes, one mode common to all pins.
// - Mode one: PWM while pressed, static level while released.
// - Mode two: flash at PWM intensity while pressed.
// - Mode three: keep PWM intensity after press then release.
// - Mode four: toggle level on every press or release edge.
// - Three power modes: active, sleep, deep sleep.
// - Active mode keeps sensing and everything running.
// - Sleep mode: wake on interval, scan sensors, sleep again.
// - Sleep mode also wakes on a GPIO interrupt.
// - Sleep interval is 1.95 ms, 15.6 ms, 125 ms or 1 s.
// - Deep sleep: no sensing or timer; a GPIO interrupt, a low sleep pin or active mode wakes.
// - Sleep timer never ends deep sleep.
// - With sleep enabled one pin is dedicated to sleep control.
// - Host pulls sleep pin low, device wakes and accepts I2C.
// - Sleep pin is selectable and lost for sensing or GPIO use.
// - Sleep pin may also signal a finger press to the host.
// - External reset is active high, pulled down outside.
// - I2C runs at 50, 100 or 400 kHz.
`timescale 1ns/1ps
module lsdc_led_sleep_ctrl #(
	parameter logic [23:0] SLP_CYC_512HZ = 24'(lsdc_pkg::SLP_CYC_512HZ),
	parameter logic [23:0] SLP_CYC_64HZ = 24'(lsdc_pkg::SLP_CYC_64HZ),
	parameter logic [23:0] SLP_CYC_8HZ = 24'(lsdc_pkg::SLP_CYC_8HZ),
	parameter logic [23:0] SLP_CYC_1HZ = 24'(lsdc_pkg::SLP_CYC_1HZ),
	parameter logic [21:0] FLASH_CYC = 22'(lsdc_pkg::FLASH_CYC)
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe_n,
	input wire logic cfgAddrWe,
	input wire logic [6:0] cfgAddr,
	input wire logic cfgAddrLock,
	output logic [6:0] slaveAddr,
	output logic addrLocked,
	output lsdc_pkg::lsdc_i2creq_t i2cReq,
	output logic [6:0] regRdIdx,
	input wire logic [7:0] regRdData,
	input wire lsdc_pkg::lsdc_pwmcfg_t pwmCfg,
	input wire lsdc_pkg::lsdc_pwr_t pwrMode,
	input wire logic [1:0] slpIntSel,
	input wire lsdc_pkg::lsdc_slpctl_t slpCtl,
	input wire logic [9:0] btnPressed,
	input wire logic [9:0] gpioIn,
	input wire logic gpioWake,
	output logic [9:0] gpioOut,
	output logic [9:0] gpioOe_n,
	output logic scanReq,
	input wire logic scanDone,
	output logic senseOn,
	output lsdc_pkg::lsdc_pst_t pwrState
);

	function automatic logic [9:0] lsdc_onehot(input logic en, input logic [3:0] sel);
		lsdc_onehot = '0;
		if (en && sel < 4'(lsdc_pkg::NPIN)) begin
			lsdc_onehot[sel] = 1'b1;
		end
	endfunction

	logic [6:0] addr_ff;
	logic lock_ff;
	logic sclPrev_ff, sdaPrev_ff;
	lsdc_pkg::lsdc_i2st_t i2St_ff;
	logic [3:0] bitCnt_ff;
	logic [7:0] shift_ff, txByte_ff;
	logic sdaDrv_ff, rw_ff, first_ff;
	logic [6:0] idx_ff;
	lsdc_pkg::lsdc_i2creq_t req_ff;
	logic [3:0] pwmCnt_ff;
	lsdc_pkg::lsdc_pwmcfg_t actCfg_ff;
	logic [21:0] flashCnt_ff;
	logic flashPhase_ff;
	logic [9:0] btnPrev_ff, holdOn_ff, toggleOn_ff;
	logic [9:0] gpioOut_ff, gpioOe_n_ff;
	lsdc_pkg::lsdc_pst_t pst_ff;
	logic [23:0] slpCnt_ff, slpLimit;
	logic scanReq_ff;
	logic sclRise, sclFall, startCond, stopCond, awake;
	logic pwmWave, anyPress, scLow, wakeAny;
	logic [9:0] scMask, lit;

	// Slave address and its lock
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			addr_ff <= lsdc_pkg::I2C_ADDR_RST;
			lock_ff <= 1'b0;
		end else begin
			if (cfgAddrLock) begin
				lock_ff <= 1'b1;
			end
			if (cfgAddrWe && !lock_ff) begin
				addr_ff <= cfgAddr;
			end
		end
	end

	assign slaveAddr = addr_ff;
	assign addrLocked = lock_ff;

	// I2C line edges; scl is slow against clk_sys at every supported rate
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sclPrev_ff <= 1'b1;
			sdaPrev_ff <= 1'b1;
		end else begin
			sclPrev_ff <= sclIn;
			sdaPrev_ff <= sdaIn;
		end
	end

	assign sclRise = sclIn && !sclPrev_ff;
	assign sclFall = !sclIn && sclPrev_ff;
	assign startCond = sclIn && sclPrev_ff && sdaPrev_ff && !sdaIn;
	assign stopCond = sclIn && sclPrev_ff && !sdaPrev_ff && sdaIn;
	assign awake = (pst_ff == lsdc_pkg::PS_RUN);

	// Slave engine; first write byte picks a command or a register index
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			i2St_ff <= lsdc_pkg::I2_IDLE;
			bitCnt_ff <= 4'h0;
			shift_ff <= 8'h00;
			txByte_ff <= 8'h00;
			sdaDrv_ff <= 1'b0;
			rw_ff <= 1'b0;
			first_ff <= 1'b0;
			idx_ff <= 7'h00;
			req_ff <= '0;
		end else begin
			req_ff.regWr <= 1'b0;
			req_ff.cmd <= 1'b0;
			if (!awake || stopCond) begin
				i2St_ff <= lsdc_pkg::I2_IDLE;
				sdaDrv_ff <= 1'b0;
			end else if (startCond) begin
				i2St_ff <= lsdc_pkg::I2_ADDR;
				bitCnt_ff <= 4'h0;
				sdaDrv_ff <= 1'b0;
			end else begin
				case (i2St_ff)
					lsdc_pkg::I2_ADDR, lsdc_pkg::I2_WDAT: begin
						if (sclRise) begin
							shift_ff <= {shift_ff[6:0], sdaIn};
							bitCnt_ff <= bitCnt_ff + 4'h1;
						end else if (sclFall && bitCnt_ff == lsdc_pkg::BITS_PER_BYTE) begin
							if (i2St_ff == lsdc_pkg::I2_ADDR) begin
								if (shift_ff[7:1] == addr_ff) begin
									i2St_ff <= lsdc_pkg::I2_AACK;
									sdaDrv_ff <= 1'b1;
									rw_ff <= shift_ff[0];
								end else begin
									i2St_ff <= lsdc_pkg::I2_IDLE;
								end
							end else begin
								i2St_ff <= lsdc_pkg::I2_WACK;
								sdaDrv_ff <= 1'b1;
								first_ff <= 1'b0;
								req_ff.data <= shift_ff;
								if (first_ff && shift_ff[lsdc_pkg::CMD_BIT]) begin
									req_ff.cmd <= 1'b1;
									req_ff.idx <= shift_ff[6:0];
								end else if (first_ff) begin
									idx_ff <= shift_ff[6:0];
								end else begin
									req_ff.regWr <= 1'b1;
									req_ff.idx <= idx_ff;
									idx_ff <= idx_ff + 7'h01;
								end
							end
						end
					end
					lsdc_pkg::I2_AACK: begin
						if (sclFall) begin
							bitCnt_ff <= 4'h0;
							if (rw_ff) begin
								i2St_ff <= lsdc_pkg::I2_RDAT;
								txByte_ff <= regRdData;
								sdaDrv_ff <= !regRdData[7];
							end else begin
								i2St_ff <= lsdc_pkg::I2_WDAT;
								sdaDrv_ff <= 1'b0;
								first_ff <= 1'b1;
							end
						end
					end
					lsdc_pkg::I2_WACK: begin
						if (sclFall) begin
							i2St_ff <= lsdc_pkg::I2_WDAT;
							sdaDrv_ff <= 1'b0;
							bitCnt_ff <= 4'h0;
						end
					end
					lsdc_pkg::I2_RDAT: begin
						if (sclFall) begin
							if (bitCnt_ff == lsdc_pkg::LAST_TX_BIT) begin
								i2St_ff <= lsdc_pkg::I2_RACK;
								sdaDrv_ff <= 1'b0;
								idx_ff <= idx_ff + 7'h01;
							end else begin
								bitCnt_ff <= bitCnt_ff + 4'h1;
								txByte_ff <= {txByte_ff[6:0], 1'b0};
								sdaDrv_ff <= !txByte_ff[6];
							end
						end
					end
					lsdc_pkg::I2_RACK: begin
						if (sclRise && sdaIn) begin
							i2St_ff <= lsdc_pkg::I2_IDLE;
						end else if (sclFall) begin
							i2St_ff <= lsdc_pkg::I2_RDAT;
							bitCnt_ff <= 4'h0;
							txByte_ff <= regRdData;
							sdaDrv_ff <= !regRdData[7];
						end
					end
					default: begin
						i2St_ff <= lsdc_pkg::I2_IDLE;
					end
				endcase
			end
		end
	end

	// Open drain: only ever pulls low
	assign sdaOut = 1'b0;
	assign sdaOe_n = !sdaDrv_ff;
	assign i2cReq = req_ff;
	assign regRdIdx = idx_ff;

	// Shared PWM; config snapped at the period end to avoid runt pulses
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pwmCnt_ff <= 4'h0;
			actCfg_ff <= '0;
		end else begin
			pwmCnt_ff <= pwmCnt_ff + 4'h1;
			if (pwmCnt_ff == lsdc_pkg::PWM_TOP) begin
				actCfg_ff <= pwmCfg;
			end
		end
	end

	assign pwmWave = (pwmCnt_ff < actCfg_ff.duty);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			flashCnt_ff <= 22'h000000;
			flashPhase_ff <= 1'b0;
		end else if (flashCnt_ff >= FLASH_CYC - 22'h000001) begin
			flashCnt_ff <= 22'h000000;
			flashPhase_ff <= !flashPhase_ff;
		end else begin
			flashCnt_ff <= flashCnt_ff + 22'h000001;
		end
	end

	// Per-pin button history for hold and toggle modes
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			btnPrev_ff <= '0;
			holdOn_ff <= '0;
			toggleOn_ff <= '0;
		end else begin
			btnPrev_ff <= btnPressed;
			holdOn_ff <= holdOn_ff | (btnPrev_ff & ~btnPressed);
			toggleOn_ff <= toggleOn_ff ^ (btnPrev_ff ^ btnPressed);
		end
	end

	always_comb begin
		case (actCfg_ff.mode)
			lsdc_pkg::DIM_FOLLOW: lit = btnPressed;
			lsdc_pkg::DIM_FLASH: lit = btnPressed & {10{flashPhase_ff}};
			lsdc_pkg::DIM_HOLD: lit = btnPressed | holdOn_ff;
			lsdc_pkg::DIM_TOGGLE: lit = toggleOn_ff;
			default: lit = btnPressed;
		endcase
	end

	assign scMask = lsdc_onehot(slpCtl.en, slpCtl.pinSel);
	assign anyPress = |(btnPressed & ~scMask);
	// Own pull-down on the sleep pin must not count as a host wake
	assign scLow = |(scMask & ~gpioIn & gpioOe_n_ff);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			gpioOut_ff <= '0;
			gpioOe_n_ff <= '1;
		end else begin
			for (int i = 0; i < lsdc_pkg::NPIN; i++) begin
				if (scMask[i]) begin
					gpioOut_ff[i] <= 1'b0;
					gpioOe_n_ff[i] <= !(slpCtl.intEn && anyPress);
				end else if (actCfg_ff.pinEn[i]) begin
					gpioOut_ff[i] <= lit[i] ? pwmWave : actCfg_ff.idleLevel;
					gpioOe_n_ff[i] <= 1'b0;
				end else begin
					gpioOut_ff[i] <= 1'b0;
					gpioOe_n_ff[i] <= 1'b1;
				end
			end
		end
	end

	assign gpioOut = gpioOut_ff;
	assign gpioOe_n = gpioOe_n_ff;

	always_comb begin
		case (slpIntSel)
			2'b00: slpLimit = SLP_CYC_512HZ;
			2'b01: slpLimit = SLP_CYC_64HZ;
			2'b10: slpLimit = SLP_CYC_8HZ;
			default: slpLimit = SLP_CYC_1HZ;
		endcase
	end

	assign wakeAny = gpioWake || scLow || (pwrMode == lsdc_pkg::PWR_ACTIVE);

	// Power sequencer; sleep only entered with the slave idle
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pst_ff <= lsdc_pkg::PS_RUN;
			slpCnt_ff <= 24'h000000;
			scanReq_ff <= 1'b0;
		end else begin
			scanReq_ff <= 1'b0;
			case (pst_ff)
				lsdc_pkg::PS_RUN: begin
					slpCnt_ff <= 24'h000000;
					if (!scLow && !gpioWake && i2St_ff == lsdc_pkg::I2_IDLE) begin
						if (pwrMode == lsdc_pkg::PWR_SLEEP) begin
							pst_ff <= lsdc_pkg::PS_SLEEP;
						end else if (pwrMode != lsdc_pkg::PWR_ACTIVE) begin
							pst_ff <= lsdc_pkg::PS_DEEP;
						end
					end
				end
				lsdc_pkg::PS_SLEEP: begin
					if (wakeAny) begin
						pst_ff <= lsdc_pkg::PS_RUN;
					end else if (slpCnt_ff >= slpLimit - 24'h000001) begin
						pst_ff <= lsdc_pkg::PS_SCAN;
						scanReq_ff <= 1'b1;
						slpCnt_ff <= 24'h000000;
					end else begin
						slpCnt_ff <= slpCnt_ff + 24'h000001;
					end
				end
				lsdc_pkg::PS_SCAN: begin
					if (wakeAny) begin
						pst_ff <= lsdc_pkg::PS_RUN;
					end else if (scanDone) begin
						pst_ff <= lsdc_pkg::PS_SLEEP;
					end
				end
				default: begin
					slpCnt_ff <= 24'h000000;
					if (wakeAny) begin
						pst_ff <= lsdc_pkg::PS_RUN;
					end
				end
			endcase
		end
	end

	assign scanReq = scanReq_ff;
	assign senseOn = (pst_ff == lsdc_pkg::PS_RUN) || (pst_ff == lsdc_pkg::PS_SCAN);
	assign pwrState = pst_ff;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	sequence sTimerDone;
		pst_ff == lsdc_pkg::PS_SLEEP && !wakeAny && slpCnt_ff >= slpLimit - 24'h000001;
	endsequence

	sequence sScanStart;
		pst_ff == lsdc_pkg::PS_SCAN && scanReq ##1 !scanReq;
	endsequence

	chk_addr_load: assert property (cfgAddrWe && !addrLocked |=> slaveAddr == $past(cfgAddr))
		else $error("address write not taken");
	chk_addr_locked: assert property (addrLocked |=> addrLocked && $stable(slaveAddr))
		else $error("locked address changed");
	chk_addr_ack: assert property (i2St_ff == lsdc_pkg::I2_AACK |-> !sdaOe_n)
		else $error("address acknowledge not driven");
	chk_cfg_boundary: assert property (actCfg_ff != $past(actCfg_ff) |-> $past(pwmCnt_ff) == lsdc_pkg::PWM_TOP)
		else $error("PWM config changed mid period");
	chk_shared_wave: assert property (1'b1 |=> ((gpioOut ^ {10{$past(pwmWave)}})
		& $past(actCfg_ff.pinEn & ~scMask & lit)) == '0)
		else $error("lit pin not on shared PWM wave");
	chk_toggle_edge: assert property (1'b1 |=> (toggleOn_ff ^ $past(toggleOn_ff))
		== $past(btnPrev_ff ^ btnPressed))
		else $error("toggle did not follow button edge");
	chk_hold_keep: assert property (1'b1 |=> ($past(holdOn_ff) & ~holdOn_ff) == '0)
		else $error("held intensity dropped");
	chk_scan_start: assert property (sTimerDone |=> sScanStart)
		else $error("sleep interval did not start a scan");
	chk_scan_end: assert property (pst_ff == lsdc_pkg::PS_SCAN && scanDone && !wakeAny
		|=> pst_ff == lsdc_pkg::PS_SLEEP)
		else $error("scan did not return to sleep");
	chk_gpio_wake: assert property (pst_ff == lsdc_pkg::PS_SLEEP && gpioWake
		|=> pst_ff == lsdc_pkg::PS_RUN)
		else $error("GPIO interrupt did not wake");
	chk_deep_stay: assert property (pst_ff == lsdc_pkg::PS_DEEP && !wakeAny
		|=> pst_ff == lsdc_pkg::PS_DEEP && !scanReq)
		else $error("deep sleep left without GPIO wake");
	chk_i2c_asleep: assert property (pst_ff != lsdc_pkg::PS_RUN |=> i2St_ff == lsdc_pkg::I2_IDLE)
		else $error("slave active while asleep");
	chk_sc_pin: assert property (!(slpCtl.intEn && anyPress) |=> ($past(scMask) & ~gpioOe_n) == '0)
		else $error("sleep pin driven as GPIO");
	chk_sc_int: assert property (slpCtl.en && slpCtl.intEn && anyPress
		|=> ($past(scMask) & (gpioOe_n | gpioOut)) == '0)
		else $error("sleep pin interrupt not driven low");

endmodule

// ---- testbench/lsdc_i2c_host.sv ----
// Host controller model: bit-level I2C master driving clock and data lines.
// Assumes an open-drain data line resolved by the bench and a pull-up on it.
`timescale 1ns/1ps
module lsdc_i2c_host (
	input wire logic clk_sys,
	input wire logic sdaLine,
	output logic scl,
	output logic sdaDrv
);
	// Seven cycles a quarter bit keeps the bit rate under 400 kHz
	localparam int Q = 7;

	initial begin
		scl = 1'b1;
		sdaDrv = 1'b1;
	end

	task automatic waitq();
		repeat (Q) @(posedge clk_sys);
	endtask

	task automatic start();
		sdaDrv <= 1'b0;
		waitq();
		scl <= 1'b0;
		waitq();
	endtask

	task automatic stop();
		sdaDrv <= 1'b0;
		waitq();
		scl <= 1'b1;
		waitq();
		sdaDrv <= 1'b1;
		waitq();
	endtask

	// Data only changes while the clock is low
	task automatic bitx(input logic b, output logic r);
		sdaDrv <= b;
		waitq();
		scl <= 1'b1;
		waitq();
		r = sdaLine;
		waitq();
		scl <= 1'b0;
		waitq();
	endtask

	// Eight bits most significant first, then the acknowledge slot
	task automatic xfer(input logic [7:0] tx, input logic ackOut, output logic [7:0] rx,
		output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bitx(tx[i], rx[i]);
		end
		bitx(ackOut, ack);
	endtask
endmodule

// ---- testbench/lsdc_led_sleep_ctrl_bench.sv ----
// Self-checking bench for the LED dimming and sleep control block.
// Assumes the host model lsdc_i2c_host; sleep and flash counts are shortened.
`timescale 1ns/1ps
module lsdc_led_sleep_ctrl_bench;
	localparam int LIM[4] = '{20, 40, 60, 80};
	localparam lsdc_pkg::lsdc_dim_t DIMSEQ[4] = '{lsdc_pkg::DIM_FOLLOW, lsdc_pkg::DIM_HOLD,
		lsdc_pkg::DIM_FLASH, lsdc_pkg::DIM_TOGGLE};
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic cfgAddrWe = 1'b0;
	logic [6:0] cfgAddr = 7'h00;
	logic cfgAddrLock = 1'b0;
	logic [7:0] regRdData = 8'h00;
	lsdc_pkg::lsdc_pwmcfg_t pwmCfg = '0;
	lsdc_pkg::lsdc_pwr_t pwrMode = lsdc_pkg::PWR_ACTIVE;
	logic [1:0] slpIntSel = 2'h0;
	lsdc_pkg::lsdc_slpctl_t slpCtl = 6'h0F;
	logic [9:0] btnPressed = 10'h000;
	logic [9:0] gpioIn = 10'h3FF;
	logic gpioWake = 1'b0;
	logic scanDone = 1'b0;
	logic scl, sdaDrv, sdaOut, sdaOe_n, addrLocked, scanReq, senseOn;
	logic [6:0] slaveAddr, regRdIdx;
	logic [9:0] gpioOut, gpioOe_n;
	lsdc_pkg::lsdc_i2creq_t i2cReq;
	lsdc_pkg::lsdc_pst_t pwrState;
	// Pulled-up open-drain data line
	wire sdaLine = sdaDrv & (sdaOe_n | sdaOut);
	int errorCnt = 0;
	int totalChecks = 0;
	int scanCnt = 0;
	int reqQ[$];

	lsdc_led_sleep_ctrl #(
		.SLP_CYC_512HZ(24'(LIM[0])),
		.SLP_CYC_64HZ(24'(LIM[1])),
		.SLP_CYC_8HZ(24'(LIM[2])),
		.SLP_CYC_1HZ(24'(LIM[3])),
		.FLASH_CYC(22'h000008)
	) uut (
		.clk_sys(clk_sys), .rst(rst), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
		.sdaOe_n(sdaOe_n), .cfgAddrWe(cfgAddrWe), .cfgAddr(cfgAddr),
		.cfgAddrLock(cfgAddrLock), .slaveAddr(slaveAddr), .addrLocked(addrLocked),
		.i2cReq(i2cReq), .regRdIdx(regRdIdx), .regRdData(regRdData), .pwmCfg(pwmCfg),
		.pwrMode(pwrMode), .slpIntSel(slpIntSel), .slpCtl(slpCtl), .btnPressed(btnPressed),
		.gpioIn(gpioIn), .gpioWake(gpioWake), .gpioOut(gpioOut), .gpioOe_n(gpioOe_n),
		.scanReq(scanReq), .scanDone(scanDone), .senseOn(senseOn), .pwrState(pwrState)
	);

	lsdc_i2c_host host (.clk_sys(clk_sys), .sdaLine(sdaLine), .scl(scl), .sdaDrv(sdaDrv));

	always #50 clk_sys = ~clk_sys;

	function automatic logic [7:0] rdFn(input logic [6:0] i);
		return {i[0], i} ^ 8'hA5;
	endfunction

	always @(posedge clk_sys) begin
		regRdData <= rdFn(regRdIdx);
	end

	task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
		totalChecks++;
		if (got !== exp) begin
			errorCnt++;
			$display("[ERR] %s expected %0h seen %0h", name, exp, got);
		end
	endtask

	// Every request pulse must match the oldest expected transfer
	always @(posedge clk_sys) begin
		if (scanReq === 1'b1) begin
			scanCnt++;
		end
		if (i2cReq.regWr === 1'b1 || i2cReq.cmd === 1'b1) begin
			if (reqQ.size() == 0) begin
				cmp("reqExtra", 16'h0000, 16'h0001);
			end else begin
				cmp("req", 16'(reqQ.pop_front()),
					{i2cReq.cmd, i2cReq.idx, i2cReq.cmd ? 8'h00 : i2cReq.data});
			end
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic waitState(input string name, input lsdc_pkg::lsdc_pst_t s);
		int n;
		n = 0;
		while (pwrState !== s && n < 300) begin
			tick(1);
			n++;
		end
		cmp(name, 16'(s), 16'(pwrState));
	endtask

	task automatic i2cWr(input logic [6:0] adr, input logic [7:0] b0, input logic [7:0] b1,
		input logic expAck);
		logic [7:0] rx;
		logic ack;
		host.start();
		host.xfer({adr, 1'b0}, 1'b1, rx, ack);
		cmp("addrAck", 16'(expAck), 16'(!ack));
		if (expAck) begin
			reqQ.push_back(b0[7] ? {1'b1, b0[6:0], 8'h00} : {1'b0, b0[6:0], b1});
			host.xfer(b0, 1'b1, rx, ack);
			if (!b0[7]) begin
				host.xfer(b1, 1'b1, rx, ack);
			end
			cmp("dataAck", 16'h0000, 16'(ack));
		end
		host.stop();
	endtask

	// Interrupt alone must wake; active mode only arrives after it
	task automatic wake(input string name);
		gpioWake <= 1'b1;
		tick(1);
		gpioWake <= 1'b0;
		pwrMode <= lsdc_pkg::PWR_ACTIVE;
		tick(1);
		cmp(name, 16'(lsdc_pkg::PS_RUN), 16'(pwrState));
	endtask

	task automatic countHigh(output int n);
		n = 0;
		repeat (16) begin
			tick(1);
			n += gpioOut[0] + gpioOut[1];
		end
	endtask

	task automatic finishTest();
		$display("Checks %0d errors %0d", totalChecks, errorCnt);
		if (errorCnt == 0 && totalChecks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		tick(30000);
		errorCnt++;
		finishTest();
	end

	initial begin
		logic [7:0] rx;
		logic [7:0] wd;
		logic [6:0] adr;
		int n, duty, sel, seen, edges;
		void'($urandom(32'hB8FB));
		edges = 0;
		tick(4);
		rst <= 1'b0;
		tick(1);
		cmp("rstAddr", 16'h0010, 16'(slaveAddr));
		cmp("rstLock", 16'h0000, 16'(addrLocked));
		cmp("rstState", 16'(lsdc_pkg::PS_RUN), 16'(pwrState));
		adr = 7'h20 + 7'($urandom_range(63));
		cfgAddr <= adr;
		cfgAddrWe <= 1'b1;
		tick(1);
		cfgAddrWe <= 1'b0;
		cfgAddrLock <= 1'b1;
		tick(1);
		cmp("newAddr", 16'(adr), 16'(slaveAddr));
		cfgAddrLock <= 1'b0;
		cfgAddr <= adr ^ 7'h01;
		cfgAddrWe <= 1'b1;
		tick(1);
		cfgAddrWe <= 1'b0;
		tick(2);
		cmp("lockedAddr", 16'(adr), 16'(slaveAddr));
		cmp("addrLocked", 16'h0001, 16'(addrLocked));
		wd = 8'($urandom);
		i2cWr(7'h10, 8'h05, wd, 1'b0);
		i2cWr(adr, 8'h05, wd, 1'b1);
		host.start();
		host.xfer({adr, 1'b1}, 1'b1, rx, wd[0]);
		host.xfer(8'hFF, 1'b1, rx, wd[1]);
		host.stop();
		cmp("rdAddrAck", 16'h0000, 16'(wd[0]));
		cmp("rdData", 16'(rdFn(7'h06)), 16'(rx));
		cmp("rdIdx", 16'h0007, 16'(regRdIdx));
		i2cWr(adr, 8'h80 | 8'($urandom_range(127)), 8'h00, 1'b1);
		// Follow runs before hold, which latches until reset; flash uses idle level 0
		for (int m = 0; m < 4; m++) begin
			duty = (m == 1 || m == 3) ? $urandom_range(14, 1) : 15;
			pwmCfg <= {10'h003, 4'(duty), DIMSEQ[m], 1'(m != 2)};
			btnPressed <= 10'h003;
			edges++;
			tick(40);
			countHigh(n);
			if (m == 2) begin
				cmp("flashPressed", 16'h0001, 16'(n >= 14 && n <= 16));
			end else begin
				seen = (m != 3 || edges % 2 == 1) ? 2 * duty : 32;
				cmp("pwmPressed", 16'(seen), 16'(n));
			end
			cmp("pinOe", 16'h0000, 16'(gpioOe_n[1:0]));
			btnPressed <= 10'h000;
			edges++;
			tick(40);
			countHigh(n);
			seen = (m == 1 || (m == 3 && edges % 2 == 1)) ? 2 * duty : (m == 2 ? 0 : 32);
			cmp("pwmReleased", 16'(seen), 16'(n));
		end
		pwmCfg <= '0;
		sel = $urandom_range(3);
		slpIntSel <= 2'(sel);
		pwrMode <= lsdc_pkg::PWR_SLEEP;
		waitState("toSleep", lsdc_pkg::PS_SLEEP);
		cmp("senseOff", 16'h0000, 16'(senseOn));
		n = 0;
		while (scanReq !== 1'b1 && n < 300) begin
			tick(1);
			n++;
		end
		cmp("slpWait", 16'h0001, 16'(n >= LIM[sel] - 2 && n <= LIM[sel] + 2));
		cmp("scanState", 16'(lsdc_pkg::PS_SCAN), 16'(pwrState));
		scanDone <= 1'b1;
		tick(1);
		scanDone <= 1'b0;
		waitState("reSleep", lsdc_pkg::PS_SLEEP);
		wake("sleepWake");
		pwrMode <= lsdc_pkg::PWR_DEEP;
		waitState("toDeep", lsdc_pkg::PS_DEEP);
		seen = scanCnt;
		tick(120);
		cmp("deepHold", 16'(lsdc_pkg::PS_DEEP), 16'(pwrState));
		cmp("deepScan", 16'(seen), 16'(scanCnt));
		wake("deepWake");
		slpCtl <= 6'h22;
		pwrMode <= lsdc_pkg::PWR_SLEEP;
		waitState("pinSleep", lsdc_pkg::PS_SLEEP);
		cmp("slpPinOe", 16'h0001, 16'(gpioOe_n[2]));
		gpioIn[2] <= 1'b0;
		tick(2);
		cmp("pinWake", 16'(lsdc_pkg::PS_RUN), 16'(pwrState));
		i2cWr(adr, 8'h09, 8'($urandom), 1'b1);
		gpioIn[2] <= 1'b1;
		pwrMode <= lsdc_pkg::PWR_ACTIVE;
		tick(10);
		// Sleep pin as press interrupt: pulled low only while a button is held
		slpCtl <= 6'h32;
		btnPressed <= 10'h001;
		tick(2);
		cmp("slpIntOe", 16'h0000, 16'(gpioOe_n[2]));
		cmp("slpIntOut", 16'h0000, 16'(gpioOut[2]));
		btnPressed <= 10'h000;
		tick(2);
		cmp("slpIntOff", 16'h0001, 16'(gpioOe_n[2]));
		cmp("reqLeft", 16'h0000, 16'(reqQ.size()));
		finishTest();
	end
endmodule
